//--- core/lmi_i2c_target.sv
// Serial target port of an LED matrix driver: decodes the bus, writes
// and reads registers through a plain register-file port.
// Assumes the system clock runs far faster than the bus clock (125 MHz
// against at most 1 MHz) and that rd_data answers rd_addr combinationally.
`default_nettype none
`timescale 1ns/1ps

// Operation
// - Respond to 7-bit address in upper bits; low bit 0 write, 1 read.
// - Address is 01101 plus strap bits set by select pin connection.
// - SDA falling while SCL high is START; then compare address byte.
// - SDA rising while SCL high is STOP; it ends the transfer.
// - Sample SDA while SCL high; bytes arrive MSB first.
// - Pull SDA low during ack pulse after own address.
// - In writes, first byte after address is the register pointer; ack it.
// - Store each data byte at the pointer and acknowledge it.
// - Pointer advances by one during each data byte acknowledge.
// - After read address ack, drive the pointed register onto SDA.
module lmi_i2c_target
    import lmi_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rstn,
    input  wire logic      scl_i,
    input  wire logic      sda_i,
    output var  logic      sda_o,
    output var  logic      sda_oe,
    input  wire logic      ad_i,
    output var  lmi_wr_s   wr_o,
    output var  lmi_byte_t rd_addr,
    input  wire lmi_byte_t rd_data
);

    lmi_pins_s  pins_raw;
    lmi_pins_s  pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       ad_s;

    logic       scl_d_reg;
    logic       scl_d_next;
    logic       sda_d_reg;
    logic       sda_d_next;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    lmi_state_e state_reg;
    lmi_state_e state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    lmi_byte_t  shift_reg;
    lmi_byte_t  shift_next;
    lmi_byte_t  ptr_reg;
    lmi_byte_t  ptr_next;
    logic       oe_reg;
    logic       oe_next;
    logic       dir_reg;
    logic       dir_next;
    lmi_wr_s    wr_reg;
    lmi_wr_s    wr_next;

    logic       idle_ad_reg;
    logic       idle_ad_next;
    logic       start_ad_reg;
    logic       start_ad_next;
    logic       low_ad_reg;
    logic       low_ad_next;
    logic       low_taken_reg;
    logic       low_taken_next;
    logic [1:0] strap_address_bits;
    logic [6:0] own_addr;

    // All three pins share one synchroniser so their timing stays aligned
    assign pins_raw = '{scl: scl_i, sda: sda_i, ad: ad_i};

    lmi_sync #(
        .WIDTH ($bits(lmi_pins_s))
    ) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .d     (pins_raw),
        .q     (pins_s)
    );

    assign scl_s = pins_s.scl;
    assign sda_s = pins_s.sda;
    assign ad_s  = pins_s.ad;

    // Edge and condition detection on the synchronised pins
    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // Strap decode from three samples of the select pin: idle (both lines
    // high), at START (SCL high, SDA low) and first SCL low after START.
    // This tells the four ties apart without any extra pin.
    always_comb begin
        if (!idle_ad_reg) begin
            strap_address_bits = LMI_STRAP_GND;
        end else if (!start_ad_reg) begin
            strap_address_bits = LMI_STRAP_SDA;
        end else if (low_ad_reg) begin
            strap_address_bits = LMI_STRAP_VCC;
        end else begin
            strap_address_bits = LMI_STRAP_SCL;
        end
    end

    assign own_addr = {LMI_FIXED_ADDR, strap_address_bits};

    // Next-state logic of the whole port
    always_comb begin
        scl_d_next     = scl_s;
        sda_d_next     = sda_s;
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        shift_next     = shift_reg;
        ptr_next       = ptr_reg;
        oe_next        = oe_reg;
        dir_next       = dir_reg;
        wr_next        = wr_reg;
        wr_next.valid  = 1'b0;
        idle_ad_next   = idle_ad_reg;
        start_ad_next  = start_ad_reg;
        low_ad_next    = low_ad_reg;
        low_taken_next = low_taken_reg;

        // Select pin sampling
        if (scl_s && sda_s) begin
            idle_ad_next = ad_s;
        end
        if (start_det) begin
            start_ad_next  = ad_s;
            low_taken_next = 1'b0;
        end else if (!scl_s && !low_taken_reg) begin
            low_ad_next    = ad_s;
            low_taken_next = 1'b1;
        end

        // START and STOP override any state; repeated START included
        if (start_det) begin
            state_next = ST_ADDR;
            cnt_next   = LMI_CNT_RESET;
            oe_next    = 1'b0;
        end else if (stop_det) begin
            state_next = ST_IDLE;
            cnt_next   = LMI_CNT_RESET;
            oe_next    = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE: begin
                    oe_next = 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        // MSB first: shift left, new bit at the bottom
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == LMI_BITS_PER_BYTE) begin
                        cnt_next = LMI_CNT_RESET;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[LMI_FIXED_MSB:LMI_STRAP_LSB] == own_addr) begin
                                state_next = ST_A_ACK;
                                oe_next    = 1'b1;
                                dir_next   = shift_reg[LMI_DIR_POS];
                            end else begin
                                state_next = ST_IGNORE;
                            end
                        end else if (state_reg == ST_REG) begin
                            state_next = ST_R_ACK;
                            oe_next    = 1'b1;
                            ptr_next   = shift_reg;
                        end else begin
                            state_next = ST_W_ACK;
                            oe_next    = 1'b1;
                            wr_next    = '{valid: 1'b1, addr: ptr_reg, data: shift_reg};
                            ptr_next   = ptr_reg + LMI_PTR_STEP;
                        end
                    end
                end
                ST_A_ACK: begin
                    if (scl_fall) begin
                        if (dir_reg == LMI_DIR_READ) begin
                            // Register content goes out right after the ack
                            state_next = ST_RDATA;
                            shift_next = rd_data;
                            oe_next    = ~rd_data[7];
                        end else begin
                            state_next = ST_REG;
                            oe_next    = 1'b0;
                        end
                    end
                end
                ST_R_ACK, ST_W_ACK: begin
                    if (scl_fall) begin
                        state_next = ST_WDATA;
                        oe_next    = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == LMI_BITS_PER_BYTE) begin
                            // Release for the master's ack; step for burst reads
                            state_next = ST_M_ACK;
                            cnt_next   = LMI_CNT_RESET;
                            oe_next    = 1'b0;
                            ptr_next   = ptr_reg + LMI_PTR_STEP;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next    = ~shift_reg[6];
                        end
                    end
                end
                ST_M_ACK: begin
                    // A missing ack ends the read; wait quietly for STOP
                    if (scl_rise) begin
                        state_next = sda_s ? ST_IGNORE : ST_M_ACKED;
                    end
                end
                ST_M_ACKED: begin
                    if (scl_fall) begin
                        state_next = ST_RDATA;
                        shift_next = rd_data;
                        oe_next    = ~rd_data[7];
                    end
                end
            endcase
        end
    end

    // State registers; nothing here but storage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg     <= 1'b1;
            sda_d_reg     <= 1'b1;
            state_reg     <= ST_IDLE;
            cnt_reg       <= LMI_CNT_RESET;
            shift_reg     <= LMI_PTR_RESET;
            ptr_reg       <= LMI_PTR_RESET;
            oe_reg        <= 1'b0;
            dir_reg       <= LMI_DIR_WRITE;
            wr_reg        <= '0;
            idle_ad_reg   <= 1'b0;
            start_ad_reg  <= 1'b0;
            low_ad_reg    <= 1'b0;
            low_taken_reg <= 1'b0;
        end else begin
            scl_d_reg     <= scl_d_next;
            sda_d_reg     <= sda_d_next;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            shift_reg     <= shift_next;
            ptr_reg       <= ptr_next;
            oe_reg        <= oe_next;
            dir_reg       <= dir_next;
            wr_reg        <= wr_next;
            idle_ad_reg   <= idle_ad_next;
            start_ad_reg  <= start_ad_next;
            low_ad_reg    <= low_ad_next;
            low_taken_reg <= low_taken_next;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sda_o   = 1'b0;
    assign sda_oe  = oe_reg;
    assign wr_o    = wr_reg;
    assign rd_addr = ptr_reg;

    // Checks on the protocol engine
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_addr_done;
        state_reg == ST_ADDR && scl_fall && cnt_reg == LMI_BITS_PER_BYTE;
    endsequence

    sequence s_read_ack_end;
        state_reg == ST_A_ACK && dir_reg == LMI_DIR_READ && scl_fall;
    endsequence

    property p_start_addr;
        start_det |=> state_reg == ST_ADDR && cnt_reg == LMI_CNT_RESET && !oe_reg;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("START did not open address phase");

    property p_stop_idle;
        stop_det && !start_det |=> state_reg == ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("STOP did not end transfer");

    property p_addr_match;
        s_addr_done |=> (state_reg == ST_A_ACK) ==
            ($past(shift_reg[LMI_FIXED_MSB:LMI_FIXED_LSB]) == LMI_FIXED_ADDR &&
             $past(shift_reg[LMI_STRAP_MSB:LMI_STRAP_LSB]) == strap_address_bits);
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("Address compare wrong");

    property p_addr_ack;
        state_reg == ST_A_ACK |-> sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("Address not acknowledged");

    property p_msb_first;
        scl_rise && state_reg == ST_REG && !start_det && !stop_det
            |=> shift_reg == {$past(shift_reg[6:0]), $past(sda_s)};
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Byte not assembled MSB first");

    property p_ptr_load;
        $rose(state_reg == ST_R_ACK) |-> ptr_reg == shift_reg && sda_oe;
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("Pointer byte not loaded");

    property p_write_step;
        wr_reg.valid |-> ptr_reg == wr_reg.addr + LMI_PTR_STEP
            && state_reg == ST_W_ACK && sda_oe;
    endproperty
    a_write_step: assert property (p_write_step)
        else $error("Write did not advance pointer");

    property p_read_start;
        s_read_ack_end and (!start_det && !stop_det)
            |=> state_reg == ST_RDATA && shift_reg == $past(rd_data)
                && sda_oe == !$past(rd_data[7]);
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("Read byte not driven after ack");

    property p_ignore_quiet;
        state_reg == ST_IGNORE |-> !sda_oe && !wr_reg.valid;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet)
        else $error("Activity while ignoring bus");

    property p_dir_write;
        s_addr_done ##1 state_reg == ST_A_ACK && dir_reg == LMI_DIR_WRITE && scl_fall
            && !start_det && !stop_det |=> state_reg == ST_REG && !sda_oe;
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("Write direction not followed");

    property p_store_data;
        state_reg == ST_WDATA && scl_fall && cnt_reg == LMI_BITS_PER_BYTE
            && !start_det && !stop_det
            |=> wr_reg.valid && wr_reg.data == $past(shift_reg);
    endproperty
    a_store_data: assert property (p_store_data)
        else $error("Data byte not stored");

endmodule

`default_nettype wire

//--- inc/lmi_pkg.sv
// Shared constants and types for the LED matrix serial target port.
// Assumes one system clock domain; all bus pins arrive asynchronously.
`default_nettype none

package lmi_pkg;

    // Target address layout: fixed upper bits, strap bits, direction bit
    localparam logic [4:0] LMI_FIXED_ADDR   = 5'h0D;  // Pattern 01101
    localparam int         LMI_FIXED_MSB    = 7;
    localparam int         LMI_FIXED_LSB    = 3;
    localparam int         LMI_STRAP_MSB    = 2;
    localparam int         LMI_STRAP_LSB    = 1;
    localparam int         LMI_DIR_POS      = 0;
    localparam logic       LMI_DIR_WRITE    = 1'h0;
    localparam logic       LMI_DIR_READ     = 1'h1;

    // Strap codes by what the select pin is tied to
    localparam logic [1:0] LMI_STRAP_GND    = 2'h0;
    localparam logic [1:0] LMI_STRAP_SCL    = 2'h1;
    localparam logic [1:0] LMI_STRAP_SDA    = 2'h2;
    localparam logic [1:0] LMI_STRAP_VCC    = 2'h3;

    // Byte framing and reset values
    localparam logic [3:0] LMI_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LMI_CNT_RESET     = 4'h0;
    localparam logic [7:0] LMI_PTR_RESET     = 8'h00;
    localparam logic [7:0] LMI_PTR_STEP      = 8'h01;
    localparam int         LMI_SYNC_STAGES   = 2;

    typedef logic [7:0] lmi_byte_t;

    // Protocol states of the target
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_A_ACK,
        ST_REG,
        ST_R_ACK,
        ST_WDATA,
        ST_W_ACK,
        ST_RDATA,
        ST_M_ACK,
        ST_M_ACKED,
        ST_IGNORE
    } lmi_state_e;

    // Bus pins as they travel through the synchroniser
    typedef struct packed {
        logic scl;
        logic sda;
        logic ad;
    } lmi_pins_s;

    // One register write toward the register file
    typedef struct packed {
        logic      valid;
        lmi_byte_t addr;
        lmi_byte_t data;
    } lmi_wr_s;

endpackage

`default_nettype wire

//--- core/lmi_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
// Assumes inputs change slowly against clock; no pulse stretching.
`default_nettype none
`timescale 1ns/1ps

module lmi_sync
    import lmi_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] q_next;

    // First stage feeds only the second stage
    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    // Reset to all ones: an idle bus reads high
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '1;
            q_reg    <= '1;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;

endmodule

`default_nettype wire

//--- dv/lmi_master_model.sv
// Behavioural bus master that talks to the LED matrix target port.
// Assumes a pull-up on SDA outside: sda_rel high lets the line float high.
`timescale 1ns/1ps
`default_nettype none

module lmi_master_model (
    output var  logic scl,
    output var  logic sda_rel,
    input  wire logic sda
);
    // Half bus period; 512 ns keeps the bus just under 1 MHz
    int half_ns = 512;

    // Bus idles with both lines released
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // START or repeated START; SDA is raised while SCL is low, then falls while SCL is high
    task automatic start_cond();
        #(half_ns / 2);
        sda_rel = 1'b1;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns);
        sda_rel = 1'b0;
        #(half_ns);
        scl = 1'b0;
    endtask

    // STOP leaves the bus idle high
    task automatic stop_cond();
        #(half_ns / 2);
        sda_rel = 1'b0;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns);
        sda_rel = 1'b1;
        #(half_ns);
    endtask

    // One clock pulse; SDA set mid-low so it never moves while SCL is high
    task automatic bit_io(input logic b, output logic s);
        #(half_ns / 2);
        sda_rel = b;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns / 2);
        s = sda;
        #(half_ns / 2);
        scl = 1'b0;
    endtask

    // Byte out MSB first, then release SDA for the target's acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Byte in; mack low leaves the last byte unacknowledged
    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~mack, s);
    endtask
endmodule

`default_nettype wire

//--- dv/test_led_matrix_i2c_target_port.sv
// Self-checking bench for the LED matrix serial target port.
// Assumes lmi_master_model drives the bus and SDA has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module test_led_matrix_i2c_target_port
    import lmi_pkg::*;
;
    typedef struct packed {
        logic [1:0] ad_mode;
        lmi_byte_t  addr;
        logic       ack;
    } lmi_row_s;

    localparam lmi_byte_t AW = {LMI_FIXED_ADDR, LMI_STRAP_GND, LMI_DIR_WRITE};
    localparam lmi_byte_t AR = {LMI_FIXED_ADDR, LMI_STRAP_GND, LMI_DIR_READ};

    logic       clock;
    logic       rstn;
    logic [1:0] ad_mode;
    wire logic  ad;
    logic       scl;
    logic       sda_rel;
    wire logic  sda;
    logic       sda_o;
    logic       sda_oe;
    lmi_wr_s    wr;
    lmi_byte_t  rd_addr;
    wire lmi_byte_t rd_data;
    lmi_byte_t  regs [256];
    lmi_byte_t  exp_regs [256];
    lmi_wr_s    wq [$];
    logic       oe_seen;
    int         error_cnt;
    int         n_checks;
    logic       ack;
    lmi_byte_t  d;
    lmi_row_s   rows [8];

    // Open-drain wire: whoever pulls low wins
    assign sda = sda_rel & (sda_oe ? sda_o : 1'b1);
    // Select pin tied to ground, supply, clock wire or data wire
    assign ad = (ad_mode == 2'h0) ? 1'b0 : (ad_mode == 2'h1) ? 1'b1 : (ad_mode == 2'h2) ? scl : sda;
    assign rd_data = regs[rd_addr];

    lmi_i2c_target DUT (
        .clock   (clock),
        .rstn    (rstn),
        .scl_i   (scl),
        .sda_i   (sda),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .ad_i    (ad),
        .wr_o    (wr),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    lmi_master_model u_mst (
        .scl     (scl),
        .sda_rel (sda_rel),
        .sda     (sda)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Register file stand-in; the log lets stray writes be seen
    always @(posedge clock) begin
        if (wr.valid === 1'b1) begin
            regs[wr.addr] <= wr.data;
            wq.push_back(wr);
        end
        if (sda_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Reset also cuts a transfer short, so outputs are checked while held
    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        check("reset oe", 17'(sda_oe), 17'h0);
        check("reset wr", wr, 17'h0);
        check("reset ptr", 17'(rd_addr), 17'h0);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic send_ok(input lmi_byte_t b);
        u_mst.send_byte(b, ack);
        check("ack", 17'(ack), 17'h1);
    endtask

    task automatic want_wr(input lmi_byte_t a, input lmi_byte_t v);
        lmi_wr_s w;
        w = (wq.size() > 0) ? wq.pop_front() : '0;
        check("write", w, {1'b1, a, v});
        exp_regs[a] = v;
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        ad_mode = 2'h0;
        oe_seen = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'hA5;
            exp_regs[i] = 8'(i) ^ 8'hA5;
        end
        // Select pin mode, address byte sent, acknowledge expected
        rows[0] = '{2'h0, {LMI_FIXED_ADDR, LMI_STRAP_GND, LMI_DIR_WRITE}, 1'b1};
        rows[1] = '{2'h0, {LMI_FIXED_ADDR, LMI_STRAP_SCL, LMI_DIR_WRITE}, 1'b0};
        rows[2] = '{2'h1, {LMI_FIXED_ADDR, LMI_STRAP_VCC, LMI_DIR_READ}, 1'b1};
        rows[3] = '{2'h1, {LMI_FIXED_ADDR, LMI_STRAP_SDA, LMI_DIR_WRITE}, 1'b0};
        rows[4] = '{2'h2, {LMI_FIXED_ADDR, LMI_STRAP_SCL, LMI_DIR_WRITE}, 1'b1};
        rows[5] = '{2'h2, {LMI_FIXED_ADDR, LMI_STRAP_GND, LMI_DIR_READ}, 1'b0};
        rows[6] = '{2'h3, {LMI_FIXED_ADDR, LMI_STRAP_SDA, LMI_DIR_READ}, 1'b1};
        rows[7] = '{2'h3, {5'h0C, LMI_STRAP_SDA, LMI_DIR_WRITE}, 1'b0};
        foreach (rows[i]) begin
            @(posedge clock);
            ad_mode <= rows[i].ad_mode;
            do_reset();
            oe_seen = 1'b0;
            u_mst.start_cond();
            u_mst.send_byte(rows[i].addr, ack);
            check("addr ack", 17'(ack), 17'(rows[i].ack));
            if (ack === 1'b1 && rows[i].addr[0] === 1'b1) begin
                u_mst.recv_byte(1'b0, d);
                check("read", 17'(d), 17'(exp_regs[0]));
            end
            u_mst.stop_cond();
            if (!rows[i].ack) begin
                check("quiet", 17'(oe_seen), 17'h0);
            end
        end
        @(posedge clock);
        ad_mode <= 2'h0;
        do_reset();

        // Slow burst whose pointer wraps past the top of the map
        u_mst.half_ns = 1024;
        u_mst.start_cond();
        send_ok(AW);
        send_ok(8'hFE);
        check("pointer", 17'(rd_addr), 17'h0FE);
        send_ok(8'h11);
        send_ok(8'h22);
        send_ok(8'h33);
        u_mst.stop_cond();
        want_wr(8'hFE, 8'h11);
        want_wr(8'hFF, 8'h22);
        want_wr(8'h00, 8'h33);
        check("pointer", 17'(rd_addr), 17'h001);
        u_mst.half_ns = 512;

        // Read back across the wrap through a repeated START
        u_mst.start_cond();
        send_ok(AW);
        send_ok(8'hFF);
        u_mst.start_cond();
        send_ok(AR);
        u_mst.recv_byte(1'b1, d);
        check("read", 17'(d), 17'(exp_regs[8'hFF]));
        u_mst.recv_byte(1'b0, d);
        check("read", 17'(d), 17'(exp_regs[8'h00]));
        u_mst.stop_cond();
        check("no write", 17'(wq.size()), 17'h0);

        // Foreign address: later bytes must find the target silent
        oe_seen = 1'b0;
        u_mst.start_cond();
        u_mst.send_byte(AW ^ 8'h02, ack);
        check("foreign ack", 17'(ack), 17'h0);
        u_mst.send_byte(8'h05, ack);
        check("ignored", 17'(ack), 17'h0);
        u_mst.stop_cond();
        check("quiet", 17'(oe_seen), 17'h0);

        // Half a data byte then STOP: nothing may be written
        u_mst.start_cond();
        send_ok(AW);
        send_ok(8'h40);
        for (int i = 0; i < 4; i++) begin
            u_mst.bit_io(1'b0, ack);
        end
        u_mst.stop_cond();
        check("partial", 17'(wq.size()), 17'h0);

        // Reset in mid-transfer, pointer must fall back
        u_mst.start_cond();
        send_ok(AW);
        send_ok(8'h10);
        do_reset();
        u_mst.stop_cond();
        tally_and_finish();
    end
endmodule

`default_nettype wire
